// File: usf_pkg.sv
/*
  Package of the serial status flag block: register indices, field
  positions, reset values, idle-line counts and the carrier structs.
  Assumes a 32-bit classic Wishbone register bus, one word per register.
*/
package usf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] USF_IDX_FRAME  = 4'h2;  // Frame format control
  localparam logic [3:0] USF_IDX_CTRL   = 4'h3;  // Interrupt enables, standby
  localparam logic [3:0] USF_IDX_STATUS = 4'h4;  // serial_status_flags
  localparam logic [3:0] USF_IDX_DATA_H = 4'h6;  // data_register_high
  localparam logic [3:0] USF_IDX_DATA_L = 4'h7;  // data_register_low
  localparam int         USF_ADDR_W     = 8;     // Decoded byte address bits
  localparam logic [1:0] USF_WORD_SHIFT = 2'h2;  // Byte address = index * 4

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int USF_B_TX_EMPTY_FLAG  = 7;  // tx_empty_flag
  localparam int USF_B_TC    = 6;  // transmit_done_flag
  localparam int USF_B_RX_FULL_FLAG  = 5;  // rx_full_flag
  localparam int USF_B_IDLE  = 4;  // Idle line flag
  localparam int USF_B_OVR   = 3;  // Overrun flag
  localparam int USF_B_NF    = 2;  // noise_flag
  localparam int USF_B_FE    = 1;  // framing_error_flag
  localparam int USF_B_PF    = 0;  // parity_error_flag
  localparam int USF_B_TIE   = 7;  // tx_empty_irq_enable
  localparam int USF_B_TCIE  = 6;  // Transmit done irq enable
  localparam int USF_B_RIE   = 5;  // rx_full_irq_enable
  localparam int USF_B_IDLE_LINE_IRQ_ENABLE  = 4;  // idle_line_irq_enable
  localparam int USF_B_RWU   = 1;  // receiver_wakeup_standby
  localparam int USF_B_NINE  = 4;  // Nine-bit format select
  localparam int USF_B_PEN   = 1;  // parity_enable
  localparam int USF_B_PODD  = 0;  // parity_odd_select
  localparam int USF_B_RX9   = 7;  // received_ninth_bit
  localparam int USF_B_TX9   = 6;  // Transmit ninth bit

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [7:0] USF_RST_CTRL  = 8'h00;
  localparam logic [7:0] USF_RST_FRAME = 8'h00;
  localparam logic [3:0] USF_IDLE_8BIT = 4'ha;  // Ones for idle, 8-bit format
  localparam logic [3:0] USF_IDLE_9BIT = 4'hb;  // Ones for idle, 9-bit format
  localparam logic [7:0] USF_TX_MASK   = 8'hc0; // Flags cleared by data write
  localparam logic [7:0] USF_RX_MASK   = 8'h3f; // Flags cleared by data read

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [8:0] data;        // Received data, bit 8 used in 9-bit format
    logic       parity_bit;  // Received parity bit
    logic       noise;       // Noise seen during the frame
    logic       stop_bit;    // Sampled stop bit level
  } usf_rx_frame_s;

  typedef struct packed {
    logic       tx_empty_flag;
    logic       tc;
    logic       rx_full_flag;
    logic       idle;
    logic       ovr;
    logic       nf;
    logic       fe;
    logic       pf;
  } usf_flags_s;

endpackage

// File: usf_status_flags.sv
/*
  Status flag logic of an asynchronous serial transmitter and receiver,
  with its Wishbone register slave and the receive and transmit data
  registers. Assumes external shifters and baud logic that signal frame
  events as one-cycle pulses synchronous to clk_i.
*/
// Notes on behaviour
// - Flags other than transmit-done clear only by status read followed later by data access.
// - Writing the status register changes nothing; it reads anytime.
// - Transmit-empty sets when the shifter takes the transmit word.
// - Transmit-empty clears on status read then data low write.
// - Transmit-done is low while sending or after preamble or break load.
// - Transmit-done rises when empty and idle; the line then idles high.
// - Transmit-done clears on status read then data low write.
// - Transmit-done clears once data, preamble or break is queued.
// - Simultaneous set and clear of transmit-done leaves it clear.
// - Receive-full sets when a frame moves into the receive register.
// - Idle sets after 10 ones in 8-bit, 11 ones in 9-bit format.
// - After idle clears, it waits for a new receive-full before setting.
// - Idle clears on status read then data low read.
// - Receiver standby stops idle from setting the idle flag.
// - Overrun sets when a second frame ends while data is unread.
// - On overrun the new frame is dropped; held data stays.
// - Overrun clears on status read then data low read.
// - Noise, framing, parity set with receive-full, never on overrun.
// - Framing error sets on a zero stop bit and blocks reception.
// - Parity error sets when enabled and received parity mismatches.
// - Noise, framing, parity clear on status read then data low read.
// - Nine-bit select picks frame size; ninth bit held in high byte.
// - Receive-full enable lets receive-full or overrun interrupt.
// - Transmit-empty enable lets transmit-empty interrupt.
// - Idle enable lets the idle flag interrupt.
`timescale 1ns/1ps

module usf_status_flags
  import usf_pkg::*;
(
  input  wire logic                clk_i,          // 20 MHz clock
  input  wire logic                rst_i,          // Synchronous reset
  input  wire logic                wb_cyc_i,       // Bus cycle
  input  wire logic                wb_stb_i,       // Strobe
  input  wire logic                wb_we_i,        // Write enable
  input  wire logic [3:0]          wb_sel_i,       // Byte selects
  input  wire logic [31:0]         wb_adr_i,       // Byte address
  input  wire logic [31:0]         wb_dat_i,       // Write data
  output logic      [31:0]         wb_dat_o,       // Read data
  output logic                     wb_ack_o,       // Acknowledge
  input  wire logic                tx_load_i,      // Shifter took the word
  input  wire logic                tx_busy_i,      // Data, preamble or break sending
  input  wire logic                tx_queue_i,     // Preamble or break queued
  input  wire logic                tx_line_i,      // Shifter line level
  output logic      [8:0]          tx_word_o,      // Word for the shifter
  output logic                     tx_valid_o,     // Word waiting for the shifter
  output logic                     txd_o,          // Transmit pin
  input  wire logic                rx_done_i,      // Frame stop bit received
  input  wire usf_rx_frame_s       rx_frame_i,     // Received frame contents
  input  wire logic                rx_tick_i,      // One receive bit time
  input  wire logic                rx_line_i,      // Receive input level
  output logic                     rx_enable_o,    // Receiver may accept frames
  output logic                     nine_bit_o,     // Frame size select
  output logic                     irq_o           // Interrupt request
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  usf_flags_s  flags;          // Live status flags
  logic [7:0]  snap;           // Flags seen by the last status read
  logic [7:0]  ctrl;           // Enables and standby
  logic [7:0]  frame_cfg;      // Frame format control
  logic [7:0]  tx_low;         // Transmit data low byte
  logic        tx_ninth;       // Transmit ninth bit
  logic [7:0]  rx_low;         // Receive data low byte
  logic        rx_ninth;       // received_ninth_bit
  logic [3:0]  idle_cnt;       // Consecutive ones on the input
  logic        idle_armed;     // A frame has arrived since idle cleared

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        acc;            // Access completes this edge
  logic        wr_acc;
  logic        rd_acc;
  logic [3:0]  idx;
  logic        adr_ok;
  logic        rd_status;
  logic        rd_low;
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctrl;
  logic        wr_frame;
  logic [7:0]  status_byte;

  // Register index from byte address
  function automatic logic [3:0] reg_index(input logic [31:0] adr);
    reg_index = adr[USF_WORD_SHIFT +: 4];
  endfunction

  // Parity mismatch over the received bits
  function automatic logic parity_bad(input usf_rx_frame_s f, input logic nine,
                                      input logic odd);
    logic ones;
    ones = nine ? ^f.data : ^f.data[7:0];
    parity_bad = (ones ^ f.parity_bit) != odd;
  endfunction

  // Access strobes qualified by ack
  assign acc       = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr_acc    = acc && wb_we_i && wb_sel_i[0];
  assign rd_acc    = acc && !wb_we_i;
  assign idx       = reg_index(wb_adr_i);
  assign adr_ok    = (wb_adr_i[31:USF_ADDR_W] == '0) && (wb_adr_i[1:0] == 2'h0)
                     && (wb_adr_i[USF_ADDR_W-1:USF_WORD_SHIFT+4] == '0);
  assign rd_status = rd_acc && adr_ok && (idx == USF_IDX_STATUS);
  assign rd_low    = rd_acc && adr_ok && (idx == USF_IDX_DATA_L);
  assign wr_low    = wr_acc && adr_ok && (idx == USF_IDX_DATA_L);
  assign wr_high   = wr_acc && adr_ok && (idx == USF_IDX_DATA_H);
  assign wr_ctrl   = wr_acc && adr_ok && (idx == USF_IDX_CTRL);
  assign wr_frame  = wr_acc && adr_ok && (idx == USF_IDX_FRAME);
  assign status_byte = flags;

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data mux, registered; status writes fall through to nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      if (adr_ok) begin
        case (idx)
          USF_IDX_FRAME:  wb_dat_o[7:0] <= frame_cfg;
          USF_IDX_CTRL:   wb_dat_o[7:0] <= ctrl;
          USF_IDX_STATUS: wb_dat_o[7:0] <= status_byte;
          USF_IDX_DATA_H: begin
            wb_dat_o[USF_B_RX9] <= rx_ninth;
            wb_dat_o[USF_B_TX9] <= tx_ninth;
          end
          USF_IDX_DATA_L: wb_dat_o[7:0] <= rx_low;
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= USF_RST_CTRL;
      frame_cfg <= USF_RST_FRAME;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wb_dat_i[7:0];
      end
      if (wr_frame) begin
        frame_cfg <= wb_dat_i[7:0];
      end
    end
  end

  assign nine_bit_o = frame_cfg[USF_B_NINE];

  // ****************************************************************
  // Clearing sequence
  // ****************************************************************
  logic [7:0] clr;             // Flags cleared this cycle
  assign clr = (rd_low ? (snap & USF_RX_MASK) : 8'h00)
             | (wr_low ? (snap & USF_TX_MASK) : 8'h00);

  // Snapshot of flags at status read, used once by data access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap <= 8'h00;
    end else if (rd_status) begin
      snap <= status_byte;
    end else begin
      snap <= snap & ~clr;
    end
  end

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  logic tc_set;
  logic tc_clr;
  assign tc_set = flags.tx_empty_flag && !tx_busy_i;
  assign tc_clr = clr[USF_B_TC] || tx_queue_i || tx_busy_i
                  || !flags.tx_empty_flag;

  // Transmit-empty and transmit-done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.tx_empty_flag <= 1'b1;
      flags.tc   <= 1'b1;
    end else begin
      if (tx_load_i) begin
        flags.tx_empty_flag <= 1'b1;
      end else if (clr[USF_B_TX_EMPTY_FLAG]) begin
        flags.tx_empty_flag <= 1'b0;
      end
      if (tc_clr) begin
        flags.tc <= 1'b0;
      end else if (tc_set) begin
        flags.tc <= 1'b1;
      end
    end
  end

  // Transmit data holding register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_low   <= 8'h00;
      tx_ninth <= 1'b0;
    end else begin
      if (wr_low) begin
        tx_low <= wb_dat_i[7:0];
      end
      if (wr_high) begin
        tx_ninth <= wb_dat_i[USF_B_TX9];
      end
    end
  end

  // Idle-high pin while transmission is complete
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
    end else begin
      txd_o <= flags.tc ? 1'b1 : tx_line_i;
    end
  end

  assign tx_word_o  = {tx_ninth, tx_low};
  assign tx_valid_o = !flags.tx_empty_flag;

  // ****************************************************************
  // Receive side
  // ****************************************************************
  logic rx_take;               // Frame moves into the data register
  logic rx_over;               // Frame lost to overrun
  logic idle_hit;
  logic [3:0] idle_lim;
  assign rx_take  = rx_done_i && !flags.fe && !flags.rx_full_flag;
  assign rx_over  = rx_done_i && !flags.fe && flags.rx_full_flag;
  assign idle_lim = frame_cfg[USF_B_NINE] ? USF_IDLE_9BIT : USF_IDLE_8BIT;
  assign idle_hit = rx_tick_i && rx_line_i && (idle_cnt == idle_lim - 4'h1);
  assign rx_enable_o = !flags.fe;

  // Receive data register, untouched on overrun
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_low   <= 8'h00;
      rx_ninth <= 1'b0;
    end else if (rx_take) begin
      rx_low   <= rx_frame_i.data[7:0];
      rx_ninth <= frame_cfg[USF_B_NINE] ? rx_frame_i.data[8] : 1'b0;
    end
  end

  // Receive flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.rx_full_flag <= 1'b0;
      flags.ovr  <= 1'b0;
      flags.nf   <= 1'b0;
      flags.fe   <= 1'b0;
      flags.pf   <= 1'b0;
    end else begin
      flags.rx_full_flag <= rx_take || (flags.rx_full_flag && !clr[USF_B_RX_FULL_FLAG]);
      flags.ovr  <= rx_over || (flags.ovr && !clr[USF_B_OVR]);
      flags.nf   <= (rx_take && rx_frame_i.noise)
                    || (flags.nf && !clr[USF_B_NF]);
      flags.fe   <= (rx_take && !rx_frame_i.stop_bit)
                    || (flags.fe && !clr[USF_B_FE]);
      flags.pf   <= (rx_take && frame_cfg[USF_B_PEN]
                     && parity_bad(rx_frame_i, frame_cfg[USF_B_NINE],
                                   frame_cfg[USF_B_PODD]))
                    || (flags.pf && !clr[USF_B_PF]);
    end
  end

  // Consecutive ones counter, saturates at the limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt <= 4'h0;
    end else if (rx_tick_i) begin
      if (!rx_line_i) begin
        idle_cnt <= 4'h0;
      end else if (idle_cnt != idle_lim) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
    end
  end

  // Idle flag and its re-arm by a received frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags.idle <= 1'b0;
      idle_armed <= 1'b0;
    end else begin
      if (rx_take) begin
        idle_armed <= 1'b1;
      end else if (clr[USF_B_IDLE]) begin
        idle_armed <= 1'b0;
      end
      if (idle_hit && idle_armed && !ctrl[USF_B_RWU]) begin
        flags.idle <= 1'b1;
      end else if (clr[USF_B_IDLE]) begin
        flags.idle <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  assign irq_o = (ctrl[USF_B_TIE]  && flags.tx_empty_flag)
              || (ctrl[USF_B_TCIE] && flags.tc)
              || (ctrl[USF_B_RIE]  && (flags.rx_full_flag || flags.ovr))
              || (ctrl[USF_B_IDLE_LINE_IRQ_ENABLE] && flags.idle);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic line_ev;
  assign line_ev = tx_load_i || tx_busy_i || tx_queue_i || rx_done_i || rx_tick_i;

  tx_empty_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load_i |=> flags.tx_empty_flag)
    else $error("transmit-empty not set after load");

  status_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && idx == USF_IDX_STATUS && !line_ev && !rd_low && !wr_low)
    |=> (status_byte == $past(status_byte)) && (snap == $past(snap)))
    else $error("status write changed state");

  tc_queue_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_queue_i && flags.tx_empty_flag && !tx_busy_i) |=> !flags.tc)
    else $error("transmit-done set while queue pending");

  tc_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flags.tc) |-> $past(flags.tx_empty_flag) && !$past(tx_busy_i) ##1 txd_o)
    else $error("transmit-done rose wrongly or pin not idle");

  ovr_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_over |=> flags.ovr && (rx_low == $past(rx_low))
                && (flags.rx_full_flag || $past(clr[USF_B_RX_FULL_FLAG])))
    else $error("overrun not flagged or data changed");

  err_with_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(flags.fe) || $rose(flags.nf) || $rose(flags.pf)) |-> $rose(flags.rx_full_flag))
    else $error("error flag set without receive-full");

  fe_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags.fe && rx_done_i) |=> $stable(rx_low) && !$rose(flags.ovr))
    else $error("reception not blocked by framing error");

  idle_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flags.idle) |-> $past(idle_armed) && !$past(ctrl[USF_B_RWU]))
    else $error("idle set while disarmed or in standby");

  clr_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flags.ovr) |-> $past(rd_low) && $past(snap[USF_B_OVR]))
    else $error("overrun cleared without the sequence");

  tx_empty_flag_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flags.tx_empty_flag) |-> $past(wr_low) && $past(snap[USF_B_TX_EMPTY_FLAG]))
    else $error("transmit-empty cleared without the sequence");

  irq_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[USF_B_RIE] && !wr_ctrl && (rx_take || rx_over)) |=> irq_o)
    else $error("receive interrupt missing");

endmodule // usf_status_flags

// File: usf_line_model.sv
/*
  Behavioural model of the shifters and remote serial device that sit
  around the status flag block. Assumes the bench paces received frames
  through send_i and frame_i, and gates bit ticks with tick_en_i.
*/
`timescale 1ns/1ps

module usf_line_model
  import usf_pkg::*;
(
  input  wire logic          clk_i,      // Clock
  input  wire logic          rst_i,      // Synchronous reset
  input  wire logic          tx_valid_i, // Word waiting
  input  wire logic          brk_i,      // Queue a break
  input  wire logic          send_i,     // Deliver frame_i
  input  wire usf_rx_frame_s frame_i,    // Frame to deliver
  input  wire logic          tick_en_i,  // Run bit ticks
  output logic               tx_load_o,  // Word taken
  output logic               tx_busy_o,  // Shifting
  output logic               tx_queue_o, // Break queued
  output logic               tx_line_o,  // Shifter line level
  output logic               rx_done_o,  // Frame ended
  output usf_rx_frame_s      rx_frame_o, // Frame contents
  output logic               rx_tick_o,  // Bit time
  output logic               rx_line_o   // Receive line level
);
  logic [4:0] cnt;
  logic       ph;

  // ****************************************************************
  // Transmit shifter
  // ****************************************************************
  // Busy and line follow the shift count; line idles high
  assign tx_queue_o = brk_i;
  assign tx_busy_o  = (cnt != 5'h00);
  assign tx_line_o  = ~cnt[0];

  // Takes a waiting word, then shifts it out for 16 cycles
  always_ff @(posedge clk_i) begin
    tx_load_o <= 1'b0;
    if (rst_i) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end else if (tx_valid_i) begin
      tx_load_o <= 1'b1;
      cnt       <= 5'h10;
    end
  end

  // ****************************************************************
  // Receive side
  // ****************************************************************
  // Frame end pulse; contents scrambled outside the pulse
  always_ff @(posedge clk_i) begin
    ph         <= rst_i ? 1'b0 : ~ph;
    rx_done_o  <= send_i & ~rst_i;
    rx_frame_o <= send_i ? frame_i : ~rx_frame_o;
    rx_tick_o  <= tick_en_i & (ph | send_i);  // Start bit ticks on either phase
    rx_line_o  <= ~send_i;
  end
endmodule // usf_line_model

// File: tb.sv
/*
  Self-checking bench of the status flag block over Wishbone.
  Assumes the line model in usf_line_model.sv and the design package.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end

module tb;
  import usf_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, brk, send, tick_en;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic tx_load_i, tx_busy_i, tx_queue_i, tx_line_i, tx_valid_o, txd_o;
  logic rx_done_i, rx_tick_i, rx_line_i, rx_enable_o, nine_bit_o, irq_o;
  logic [8:0] tx_word_o;
  logic [7:0] q;
  usf_rx_frame_s rx_frame_i, frame;
  int mismatches, n_tests;

  usf_status_flags dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_load_i, .tx_busy_i, .tx_queue_i,
    .tx_line_i, .tx_word_o, .tx_valid_o, .txd_o, .rx_done_i, .rx_frame_i, .rx_tick_i,
    .rx_line_i, .rx_enable_o, .nine_bit_o, .irq_o);
  usf_line_model line (.clk_i, .rst_i, .tx_valid_i(tx_valid_o), .brk_i(brk),
    .send_i(send), .frame_i(frame), .tick_en_i(tick_en), .tx_load_o(tx_load_i),
    .tx_busy_o(tx_busy_i), .tx_queue_o(tx_queue_i), .tx_line_o(tx_line_i),
    .rx_done_o(rx_done_i), .rx_frame_o(rx_frame_i), .rx_tick_o(rx_tick_i),
    .rx_line_o(rx_line_i));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Closing report and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Waits n edges, then settles at the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // One classic Wishbone cycle; read byte lands in q
  task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {26'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(negedge clk_i);
  endtask

  // Status read against an expected value
  task automatic st(input logic [7:0] e);
    wb(USF_IDX_STATUS, 1'b0, 8'h00);
    `CHK("status", e, q)
  endtask

  // One received frame from the line model
  task automatic rx(input logic [8:0] d, input logic p, input logic nz, input logic sb);
    @(posedge clk_i);
    frame <= '{d, p, nz, sb};
    send  <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    wt(3);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk_i);
    mismatches++;
    test_done();
  end

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Tests
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, brk, send, tick_en} = 7'h40;
    {wb_sel_i, wb_adr_i, wb_dat_i, frame} = '0;
    wb_sel_i = 4'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(USF_IDX_DATA_L, 1'b1, 8'h11);
    wt(2);
    `CHK("tx_valid", 1'b0, tx_valid_o)
    st(8'hc0);
    wb(USF_IDX_STATUS, 1'b1, 8'hff);
    st(8'hc0);
    wb(USF_IDX_CTRL, 1'b1, 8'h80);
    `CHK("irq", 1'b1, irq_o)
    wb(USF_IDX_DATA_L, 1'b1, 8'h55);
    `CHK("tx_valid", 1'b1, tx_valid_o)
    wt(4);
    `CHK("tx_word", 9'h055, tx_word_o)
    st(8'h80);
    wt(24);
    st(8'hc0);
    `CHK("txd", 1'b1, txd_o)
    wb(USF_IDX_CTRL, 1'b1, 8'h20);
    rx(9'h0a5, 1'b0, 1'b0, 1'b1);
    `CHK("irq", 1'b1, irq_o)
    rx(9'h03c, 1'b0, 1'b0, 1'b1);
    st(8'he8);
    wb(USF_IDX_DATA_L, 1'b0, 8'h00);
    `CHK("data", 8'ha5, q)
    st(8'hc0);
    wb(USF_IDX_FRAME, 1'b1, 8'h02);
    rx(9'h001, 1'b0, 1'b1, 1'b0);
    st(8'he7);
    `CHK("rx_enable", 1'b0, rx_enable_o)
    rx(9'h002, 1'b1, 1'b0, 1'b1);
    st(8'he7);
    wb(USF_IDX_DATA_L, 1'b0, 8'h00);
    `CHK("data", 8'h01, q)
    st(8'hc0);
    `CHK("rx_enable", 1'b1, rx_enable_o)
    wb(USF_IDX_FRAME, 1'b1, 8'h10);
    `CHK("nine_bit", 1'b1, nine_bit_o)
    rx(9'h1c3, 1'b0, 1'b0, 1'b1);
    st(8'he0);
    wb(USF_IDX_DATA_H, 1'b0, 8'h00);
    `CHK("data_high", 8'h80, q)
    wb(USF_IDX_DATA_L, 1'b0, 8'h00);
    `CHK("data", 8'hc3, q)
    @(posedge clk_i);
    brk <= 1'b1;
    wt(2);
    st(8'h80);
    @(posedge clk_i);
    brk <= 1'b0;
    wb(USF_IDX_CTRL, 1'b1, 8'h12);
    @(posedge clk_i);
    tick_en <= 1'b1;
    wt(40);
    st(8'hc0);
    wb(USF_IDX_CTRL, 1'b1, 8'h10);
    rx(9'h0f0, 1'b0, 1'b0, 1'b1);
    wt(40);
    st(8'hf0);
    `CHK("irq", 1'b1, irq_o)
    rx(9'h00f, 1'b0, 1'b0, 1'b1);
    wb(USF_IDX_DATA_L, 1'b0, 8'h00);
    `CHK("data", 8'hf0, q)
    `CHK("irq", 1'b0, irq_o)
    wt(40);
    st(8'hc8);
    wb(USF_IDX_DATA_L, 1'b0, 8'h00);
    st(8'hc0);
    test_done();
  end
endmodule // tb
